// [dv/imc_monitor.sv]
// Port-level assertions for the interface mode and clock block
`timescale 1ns/1ps
module imc_monitor (
  input logic       clock,
  input logic       sys_rst,
  input logic       clk_en,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       ref_tick,
  input logic       pll_tick,
  input logic       full_duplex_mode,
  input logic       half_duplex_10bit_mode,
  input logic       half_duplex_20bit_mode,
  input logic       clone_mode_active,
  input logic       tx_direction_active,
  input logic       rx_direction_active,
  input logic       loopback_active,
  input logic [2:0] pll_mult_code,
  input logic [4:0] pll_mult_factor,
  input logic       pll_mult_invalid,
  input logic       pll_running,
  input logic       tx_clk_tick,
  input logic       rx_clk_tick,
  input logic [9:0] dac_word,
  input logic       dac_word_valid,
  input logic [9:0] rx_bus_word,
  input logic       rx_bus_valid
);
  // ----------------------------------------
  // Shadow of the clock source bits
  // ----------------------------------------
  logic bypass_q;
  logic alt_q;
  logic div5_q;
  logic rx_pll_sel;
  logic rx_src;
  logic tx_pll_div1;
  logic cfg_wr;
  logic fd_w;
  logic half_duplex_10bit_mode_w;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bypass_q <= 1'b0;
      alt_q    <= 1'b0;
      div5_q   <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == 8'h0f) begin
      bypass_q <= reg_wdata[7];
      alt_q    <= reg_wdata[4];
      div5_q   <= reg_wdata[3];
    end
  end
  assign rx_pll_sel  = alt_q && !bypass_q;
  assign rx_src      = rx_pll_sel ? pll_tick : ref_tick;
  assign tx_pll_div1 = !bypass_q && !div5_q;
  assign cfg_wr      = clk_en && reg_wr && (reg_addr == 8'h0e);
  assign fd_w        = reg_wdata[4] && !reg_wdata[0];
  assign half_duplex_10bit_mode_w      = reg_wdata[2] && !reg_wdata[4] && !reg_wdata[0];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst || !clk_en);

  AST_LOOP_WR: assert property (cfg_wr |=> ##1 loopback_active == $past(reg_wdata[5], 2))
    else $error("loopback level differs from written bit");
  AST_DUPLEX_WR: assert property (cfg_wr |=> ##1 full_duplex_mode == $past(fd_w, 2))
    else $error("full duplex level differs from written bits");
  AST_WIDTH_WR: assert property (cfg_wr |=> ##1 half_duplex_10bit_mode == $past(half_duplex_10bit_mode_w, 2))
    else $error("ten bit mode differs from written bits");
  AST_MODE_ONE: assert property (
    $onehot({full_duplex_mode, half_duplex_10bit_mode, half_duplex_20bit_mode,
             clone_mode_active}))
    else $error("interface mode outputs not one hot");
  AST_HD_DIR: assert property (
    (half_duplex_10bit_mode || half_duplex_20bit_mode) |->
    tx_direction_active != rx_direction_active)
    else $error("half duplex needs exactly one direction");
  AST_MULT_MAP: assert property (
    pll_mult_factor == ((pll_mult_code > 3'h4) ? 5'h01 : (5'h01 << pll_mult_code)) &&
    pll_mult_invalid == (pll_mult_code > 3'h4))
    else $error("multiplier factor does not match code");
  AST_PLL_RUN: assert property (!$past(sys_rst) |-> pll_running)
    else $error("loop stopped outside reset");
  AST_RX_SRC: assert property (
    !$past(sys_rst) && $past(clk_en) && $past(rx_pll_sel) == $past(rx_pll_sel, 2) |->
    rx_clk_tick == $past(rx_src))
    else $error("receive tick from wrong source");
  AST_TX_BYP: assert property (
    !$past(sys_rst) && $past(clk_en) && $past(bypass_q) && $past(bypass_q, 2) |->
    tx_clk_tick == $past(ref_tick))
    else $error("bypassed transmit tick not from reference");
  AST_TX_PLL: assert property (
    !$past(sys_rst, 2) && !$past(sys_rst) && $past(tx_pll_div1) && $past(tx_pll_div1, 2) &&
    $past(clk_en) && $past(clk_en, 2) &&
    $past(tx_pll_div1, 3) |-> tx_clk_tick == $past(pll_tick, 2))
    else $error("undivided transmit tick not from loop");
  AST_LOOP_ECHO: assert property (
    loopback_active && dac_word_valid |=> rx_bus_valid && rx_bus_word == $past(dac_word))
    else $error("loopback word not echoed on receive bus");

  COV_LOOP: cover property (loopback_active && rx_bus_valid);
  COV_DIV5: cover property (div5_q && !bypass_q && tx_clk_tick);
  COV_BYP: cover property (bypass_q && tx_clk_tick);
endmodule // imc_monitor

bind imc_top imc_monitor u_mon (.*);

// [dv/imc_partner.sv]
// Back-end model: sends transmit words and counts receive bus words
`timescale 1ns/1ps
module imc_partner #(
  parameter int GAP = 20
) (
  input  logic       clock,
  input  logic       sys_rst,
  input  logic       go,
  input  logic [9:0] rx_bus_word,
  input  logic       rx_bus_valid,
  output logic [9:0] tx_word_in,
  output logic       tx_word_valid,
  output logic [7:0] rx_cnt,
  output logic [9:0] rx_last
);
  // ----------------------------------------
  // Word source and receive counter
  // ----------------------------------------
  int n;
  int t;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      n             <= 4;
      t             <= 0;
      tx_word_valid <= 1'b0;
      tx_word_in    <= 10'h000;
      rx_cnt        <= 8'h00;
      rx_last       <= 10'h000;
    end else begin
      // Idle data toggles so a stale word is never taken for a live one
      tx_word_valid <= 1'b0;
      tx_word_in    <= ~tx_word_in;
      if (go) begin
        n      <= 0;
        t      <= 0;
        rx_cnt <= 8'h00;
      end else if (n < 4) begin
        t <= (t == GAP - 1) ? 0 : t + 1;
        if (t == GAP - 1)
          n <= n + 1;
        if (t == 0) begin
          tx_word_valid <= 1'b1;
          tx_word_in    <= 10'h2a5 + 10'(n);
        end
      end
      if (rx_bus_valid) begin
        rx_cnt  <= rx_cnt + 8'h01;
        rx_last <= rx_bus_word;
      end
    end
  end
endmodule // imc_partner

// [dv/imc_tb_top.sv]
// Self-checking testbench for the interface mode and clock block
`timescale 1ns/1ps
module imc_tb_top;
  // ----------------------------------------
  // Signals, design and back end
  // ----------------------------------------
  localparam logic [15:0] NPLL = 16'h64;  // Loop ticks in 200 cycles
  localparam logic [15:0] NREF = 16'h32;  // Reference ticks in 200 cycles
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       direction_pin = 1'b0;
  logic       ref_tick = 1'b0;
  logic       pll_tick = 1'b0;
  logic [9:0] adc_word = 10'h000;
  logic       adc_word_valid = 1'b0;
  logic       second_pin_func = 1'b1;
  logic       go = 1'b0;
  logic [7:0] cyc = 8'h00;
  logic [7:0] reg_rdata, rx_cnt;
  logic [9:0] tx_word_in, dac_word, rx_bus_word, rx_last;
  logic [2:0] pll_mult_code;
  logic [4:0] pll_mult_factor;
  logic       tx_word_valid, full_duplex_mode, half_duplex_10bit_mode, half_duplex_20bit_mode;
  logic       clone_mode_active, tx_direction_active, rx_direction_active, loopback_active;
  logic       pll_mult_invalid, pll_running, tx_clk_tick, rx_clk_tick, adc_clk_tick;
  logic       second_interface_pin, dac_word_valid, rx_bus_valid;
  int         err_total = 0;
  int         checks_done = 0;

  imc_top dut (.*);
  imc_partner u_back_end (.*);

  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc      <= cyc + 8'h01;
    ref_tick <= (cyc[1:0] == 2'b00);
    pll_tick <= cyc[0];
  end

  // ----------------------------------------
  // Bus, compare and count tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  function automatic logic [15:0] modes();
    return {12'h0, full_duplex_mode, half_duplex_10bit_mode, half_duplex_20bit_mode,
            clone_mode_active};
  endfunction
  function automatic logic [15:0] dirs();
    return {14'h0, tx_direction_active, rx_direction_active};
  endfunction
  task automatic count(output logic [15:0] ntx, nrx, nadc, npin);
    ntx  = 16'h0;
    nrx  = 16'h0;
    nadc = 16'h0;
    npin = 16'h0;
    repeat (200) begin
      @(posedge clock);
      #1;
      ntx  = ntx + {15'h0, tx_clk_tick === 1'b1};
      nrx  = nrx + {15'h0, rx_clk_tick === 1'b1};
      nadc = nadc + {15'h0, adc_clk_tick === 1'b1};
      npin = npin + {15'h0, second_interface_pin === 1'b1};
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk(8'h0e, 8'h10);
    rd_chk(8'h0f, 8'h00);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h0d, 8'h00);
    rd_chk(8'h22, 8'h00);
    chk("modes", 16'h8, modes());
    rd_chk(8'h1f, 8'h08);
    clk_en <= 1'b0;
    wr(8'h0e, 8'h00);
    clk_en <= 1'b1;
    rd_chk(8'h0e, 8'h10);
  endtask
  task automatic t_mult;
    for (int c = 0; c < 8; c++) begin
      wr(8'h0f, 8'(c));
      settle;
      chk("mult", (c < 5) ? (16'h1 << c) : 16'h1, {11'h0, pll_mult_factor});
      chk("minv", 16'(c > 4), {15'h0, pll_mult_invalid});
      rd_chk(8'h0f, 8'(c));
    end
    wr(8'h0f, 8'h00);
  endtask
  task automatic t_modes;
    logic [7:0] cfg [6] = '{8'h10, 8'h14, 8'h04, 8'h00, 8'h11, 8'h05};
    logic [15:0] em [6] = '{16'h8, 16'h8, 16'h4, 16'h2, 16'h1, 16'h1};
    wr(8'h01, 8'he0);
    for (int i = 0; i < 6; i++) begin
      wr(8'h0e, cfg[i]);
      settle;
      chk("modes", em[i], modes());
    end
    wr(8'h01, 8'h00);
  endtask
  task automatic t_direction;
    wr(8'h0e, 8'h0a);
    settle;
    chk("dir", 16'h2, dirs());
    wr(8'h0e, 8'h02);
    settle;
    chk("dir", 16'h1, dirs());
    wr(8'h0e, 8'h08);
    settle;
    chk("dir", 16'h1, dirs());
    @(posedge clock);
    direction_pin <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk("dir", 16'h2, dirs());
    wr(8'h0e, 8'h10);
    settle;
    chk("dir", 16'h3, dirs());
    adc_word       <= 10'h155;
    adc_word_valid <= 1'b1;
    @(posedge clock);
    adc_word_valid <= 1'b0;
    #1;
    chk("rx_bus", 16'h555, {5'h0, rx_bus_valid, rx_bus_word});
  endtask
  task automatic t_clock_src;
    logic [7:0] cfg [8] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h30, 8'h80, 8'h88, 8'h90};
    logic [15:0] etx [8] = '{NPLL, NPLL / 5, NPLL, NPLL, NPLL, NREF, NREF, NREF};
    logic [15:0] erx [8] = '{NREF, NREF, NPLL, NREF, NPLL, NREF, NREF, NREF};
    logic [15:0] ead [8] = '{NREF, NREF, NPLL, NREF / 2, NPLL / 2, NREF, NREF, NREF};
    logic [15:0] a, b, c, d;
    for (int i = 0; i < 8; i++) begin
      wr(8'h0f, cfg[i]);
      repeat (12) @(posedge clock);
      count(a, b, c, d);
      chk("tx_clk_tick", etx[i], a);
      chk("rx_clk_tick", erx[i], b);
      chk("adc_clk_tick", ead[i], c);
      chk("pll_running", 16'h1, {15'h0, pll_running});
    end
    wr(8'h0f, 8'h00);
  endtask
  task automatic t_second_pin;
    logic [15:0] a, b, c, d;
    wr(8'h10, 8'h20);
    rd_chk(8'h10, 8'h20);
    count(a, b, c, d);
    chk("pin2 fd", NPLL, d);
    wr(8'h0e, 8'h00);
    settle;
    count(a, b, c, d);
    chk("pin2 hd", NPLL * 2, d);
    wr(8'h01, 8'h04);
    settle;
    count(a, b, c, d);
    chk("pin2 hd en", NPLL, d);
    wr(8'h01, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h0e, 8'h10);
  endtask
  task automatic t_loopback;
    wr(8'h0e, 8'h10);
    wr(8'h0e, 8'h30);
    rd_chk(8'h0e, 8'h30);
    for (int k = 0; k < 3; k++) begin
      wr(8'h0d, 8'(k));
      rd_chk(8'h0d, 8'(k));
      @(posedge clock);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (110) @(posedge clock);
      #1;
      chk("loop count", 16'h4 << k, {8'h00, rx_cnt});
      chk("loop word", 16'h2a8, {6'h0, rx_last});
    end
    wr(8'h0d, 8'h00);
    wr(8'h0e, 8'h10);
  endtask

  // ----------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------
  task automatic tally_and_finish;
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset;
    t_mult;
    t_modes;
    t_direction;
    t_clock_src;
    t_second_pin;
    t_loopback;
    tally_and_finish;
  end
  initial begin
    // Tests need about 2900 cycles; about seven times that means a hang
    #200000;
    err_total++;
    tally_and_finish;
  end
endmodule // imc_tb_top

// [hdl/imc_tick_div.v]
// Clock-enable divider: passes one input tick out of every ratio ticks
`timescale 1ns/1ps
module imc_tick_div (
  clock,
  sys_rst,
  clk_en,
  tick_in,
  ratio,
  tick_out
);
  input  wire       clock;
  input  wire       sys_rst;
  input  wire       clk_en;
  input  wire       tick_in;
  input  wire [2:0] ratio;
  output reg        tick_out;

  reg [2:0] count_q;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Ratio 0 or 1 passes every tick; a ratio change keeps the count, so the first tick after it may pass early
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_q  <= 3'h0;
      tick_out <= 1'b0;
    end else if (clk_en) begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (ratio <= 3'h1 || count_q >= ratio - 3'h1) begin
          count_q  <= 3'h0;
          tick_out <= 1'b1;
        end else begin
          count_q <= count_q + 3'h1;
        end
      end
    end
  end
endmodule // imc_tick_div

// [hdl/imc_top.v]
// Interface mode and clock source configuration with digital loopback path
`timescale 1ns/1ps
`include "imc_defs.vh"
module imc_top (
  clock,
  sys_rst,
  clk_en,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  direction_pin,
  ref_tick,
  pll_tick,
  tx_word_in,
  tx_word_valid,
  adc_word,
  adc_word_valid,
  second_pin_func,
  full_duplex_mode,
  half_duplex_10bit_mode,
  half_duplex_20bit_mode,
  clone_mode_active,
  tx_direction_active,
  rx_direction_active,
  loopback_active,
  pll_mult_code,
  pll_mult_factor,
  pll_mult_invalid,
  pll_running,
  tx_clk_tick,
  rx_clk_tick,
  adc_clk_tick,
  second_interface_pin,
  dac_word,
  dac_word_valid,
  rx_bus_word,
  rx_bus_valid
);
  input  wire       clock;
  input  wire       sys_rst;
  input  wire       clk_en;
  input  wire [7:0] reg_addr;
  input  wire [7:0] reg_wdata;
  input  wire       reg_wr;
  input  wire       reg_rd;
  output reg  [7:0] reg_rdata;
  input  wire       direction_pin;
  input  wire       ref_tick;
  input  wire       pll_tick;
  input  wire [9:0] tx_word_in;
  input  wire       tx_word_valid;
  input  wire [9:0] adc_word;
  input  wire       adc_word_valid;
  input  wire       second_pin_func;
  output reg        full_duplex_mode;
  output reg        half_duplex_10bit_mode;
  output reg        half_duplex_20bit_mode;
  output reg        clone_mode_active;
  output reg        tx_direction_active;
  output reg        rx_direction_active;
  output reg        loopback_active;
  output reg  [2:0] pll_mult_code;
  output reg  [4:0] pll_mult_factor;
  output reg        pll_mult_invalid;
  output reg        pll_running;
  output reg        tx_clk_tick;
  output reg        rx_clk_tick;
  output reg        adc_clk_tick;
  output reg        second_interface_pin;
  output reg  [9:0] dac_word;
  output reg        dac_word_valid;
  output reg  [9:0] rx_bus_word;
  output reg        rx_bus_valid;

  localparam [1:0] ST_IDLE   = 2'b01;
  localparam [1:0] ST_REPEAT = 2'b10;

  reg  [7:0] clk_mode_q;
  reg  [7:0] data_path_q;
  reg  [7:0] iface_cfg_q;
  reg  [7:0] clk_cfg_pri_q;
  reg  [7:0] clk_cfg_sec_q;
  reg        dir_meta_q;
  reg        dir_sync_q;
  reg  [1:0] state_q;
  reg  [1:0] rep_cnt_q;
  reg  [9:0] pend_word_q;
  reg        pend_valid_q;
  reg  [9:0] hold_word_q;
  reg  [7:0] status_d;
  reg  [4:0] factor_d;
  reg        invalid_d;
  reg  [1:0] interp_reps_d;

  wire       loop_on;
  wire       clone_on;
  wire       duplex_full;
  wire       fd_d;
  wire       half_duplex_10bit_mode_d;
  wire       half_duplex_20bit_mode_d;
  wire       dir_eff;
  wire       bypass;
  wire       alt_timing;
  wire       pin2_valid;
  wire       accept_tx;
  wire       div5_tick;
  wire       adc_src_tick;
  wire       adc_div_tick;
  wire       tx_tick_d;
  wire [1:0] interp_code;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clk_mode_q    <= `IMC_RST_CLK_MODE;
      data_path_q   <= `IMC_RST_DATA_PATH;
      iface_cfg_q   <= `IMC_RST_IFACE_CFG;
      clk_cfg_pri_q <= `IMC_RST_CLK_CFG_PRI;
      clk_cfg_sec_q <= `IMC_RST_CLK_CFG_SEC;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        `IMC_OFS_CLK_MODE: begin
          // Only the clock mode field and the second pin enable are held here
          clk_mode_q <= {reg_wdata[`IMC_MSB_CLK_MODE:`IMC_LSB_CLK_MODE], 2'h0,
                         reg_wdata[`IMC_BIT_PIN2_ENABLE], 2'h0};
        end
        `IMC_OFS_DATA_PATH:   data_path_q   <= {6'h00, reg_wdata[`IMC_MSB_INTERP:0]};
        `IMC_OFS_IFACE_CFG:   iface_cfg_q   <= {2'h0, reg_wdata[5:0]};
        `IMC_OFS_CLK_CFG_PRI: clk_cfg_pri_q <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
        `IMC_OFS_CLK_CFG_SEC: begin
          clk_cfg_sec_q <= {2'h0, reg_wdata[5], 2'h0, reg_wdata[2], 2'h0};
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `IMC_OFS_CLK_MODE:    reg_rdata <= clk_mode_q;
          `IMC_OFS_DATA_PATH:   reg_rdata <= data_path_q;
          `IMC_OFS_IFACE_CFG:   reg_rdata <= iface_cfg_q;
          `IMC_OFS_CLK_CFG_PRI: reg_rdata <= clk_cfg_pri_q;
          `IMC_OFS_CLK_CFG_SEC: reg_rdata <= clk_cfg_sec_q;
          `IMC_OFS_STATUS:      reg_rdata <= status_d;
          default:              reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Interface mode decode
  // ---------------------------------------------------------------
  assign loop_on     = iface_cfg_q[`IMC_BIT_LOOPBACK];
  assign clone_on    = iface_cfg_q[`IMC_BIT_CLONE];
  // Clone mode relies on software also writing clock mode 111; not enforced
  assign duplex_full = iface_cfg_q[`IMC_BIT_DUPLEX] & ~clone_on;
  assign fd_d        = duplex_full;
  assign half_duplex_10bit_mode_d      = ~clone_on & ~duplex_full & iface_cfg_q[`IMC_BIT_WIDTH_10];
  assign half_duplex_20bit_mode_d      = ~clone_on & ~duplex_full & ~iface_cfg_q[`IMC_BIT_WIDTH_10];
  assign dir_eff     = iface_cfg_q[`IMC_BIT_DIR_OVERRIDE] ?
                       iface_cfg_q[`IMC_BIT_DIRECTION] : dir_sync_q;

  // The direction pin is asynchronous to this clock
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dir_meta_q <= 1'b0;
      dir_sync_q <= 1'b0;
    end else if (clk_en) begin
      dir_meta_q <= direction_pin;
      dir_sync_q <= dir_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Clock source selection
  // ---------------------------------------------------------------
  assign bypass       = clk_cfg_pri_q[`IMC_BIT_PLL_BYPASS];
  assign alt_timing   = clk_cfg_pri_q[`IMC_BIT_ALT_TIMING];
  assign interp_code  = data_path_q[`IMC_MSB_INTERP:0];
  assign adc_src_tick = (alt_timing && !bypass) ? pll_tick : ref_tick;
  assign tx_tick_d    = bypass ? ref_tick : div5_tick;
  assign pin2_valid   = clk_cfg_sec_q[`IMC_BIT_LOOP_TO_PIN2] &
                        (fd_d | clk_mode_q[`IMC_BIT_PIN2_ENABLE]);

  imc_tick_div u_div5 (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .tick_in  (pll_tick),
    .ratio    (clk_cfg_pri_q[`IMC_BIT_DIV5] ? `IMC_RATIO_DIV5 : `IMC_RATIO_NONE),
    .tick_out (div5_tick)
  );

  imc_tick_div u_adc_div (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .tick_in  (adc_src_tick),
    .ratio    (clk_cfg_pri_q[`IMC_BIT_ADC_DIV2] ? `IMC_RATIO_DIV2 : `IMC_RATIO_NONE),
    .tick_out (adc_div_tick)
  );

  always @* begin
    invalid_d = 1'b0;
    case (clk_cfg_pri_q[`IMC_MSB_MULT:0])
      `IMC_MULT_1X:  factor_d = 5'h01;
      `IMC_MULT_2X:  factor_d = 5'h02;
      `IMC_MULT_4X:  factor_d = 5'h04;
      `IMC_MULT_8X:  factor_d = 5'h08;
      `IMC_MULT_16X: factor_d = 5'h10;
      default: begin
        factor_d  = 5'h01;
        invalid_d = 1'b1;
      end
    endcase
    case (interp_code)
      `IMC_INTERP_2X: interp_reps_d = 2'h1;
      `IMC_INTERP_4X: interp_reps_d = 2'h3;
      default:        interp_reps_d = 2'h0;
    endcase
    status_d = {loop_on, clone_on, half_duplex_20bit_mode_d, half_duplex_10bit_mode_d, fd_d, dir_eff, invalid_d, pin2_valid};
  end

  // ---------------------------------------------------------------
  // Registered mode and clock outputs
  // ---------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      full_duplex_mode       <= 1'b1;
      half_duplex_10bit_mode <= 1'b0;
      half_duplex_20bit_mode <= 1'b0;
      clone_mode_active      <= 1'b0;
      tx_direction_active    <= 1'b1;
      rx_direction_active    <= 1'b1;
      loopback_active        <= 1'b0;
      pll_mult_code          <= `IMC_MULT_1X;
      pll_mult_factor        <= 5'h01;
      pll_mult_invalid       <= 1'b0;
      pll_running            <= 1'b0;
      tx_clk_tick            <= 1'b0;
      rx_clk_tick            <= 1'b0;
      adc_clk_tick           <= 1'b0;
      second_interface_pin   <= 1'b0;
    end else if (clk_en) begin
      full_duplex_mode       <= fd_d;
      half_duplex_10bit_mode <= half_duplex_10bit_mode_d;
      half_duplex_20bit_mode <= half_duplex_20bit_mode_d;
      clone_mode_active      <= clone_on;
      tx_direction_active    <= fd_d | dir_eff;
      rx_direction_active    <= fd_d | ~dir_eff;
      loopback_active        <= loop_on;
      pll_mult_code          <= clk_cfg_pri_q[`IMC_MSB_MULT:0];
      pll_mult_factor        <= factor_d;
      pll_mult_invalid       <= invalid_d;
      // The loop is never stopped by bypass, so relocking is not needed on exit
      pll_running            <= 1'b1;
      tx_clk_tick            <= tx_tick_d;
      rx_clk_tick            <= (alt_timing && !bypass) ? pll_tick : ref_tick;
      adc_clk_tick           <= adc_div_tick;
      second_interface_pin   <= pin2_valid ? pll_tick : second_pin_func;
    end
  end

  // ---------------------------------------------------------------
  // Transmit path with hold interpolation
  // ---------------------------------------------------------------
  // In loopback the bus is taken as in full duplex whatever the mode bits say,
  // since the controller is expected to have set full duplex first
  assign accept_tx = tx_word_valid & (loop_on | fd_d | dir_eff);

  // One pending word only; a newer word overwrites one not yet sent
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q        <= ST_IDLE;
      rep_cnt_q      <= 2'h0;
      pend_word_q    <= 10'h000;
      pend_valid_q   <= 1'b0;
      hold_word_q    <= 10'h000;
      dac_word       <= 10'h000;
      dac_word_valid <= 1'b0;
    end else if (clk_en) begin
      dac_word_valid <= 1'b0;
      if (accept_tx) begin
        pend_word_q  <= tx_word_in;
        pend_valid_q <= 1'b1;
      end
      if (tx_clk_tick) begin
        case (state_q)
          ST_IDLE: begin
            if (pend_valid_q) begin
              dac_word       <= pend_word_q;
              dac_word_valid <= 1'b1;
              hold_word_q    <= pend_word_q;
              rep_cnt_q      <= interp_reps_d;
              if (!accept_tx) begin
                pend_valid_q <= 1'b0;
              end
              if (interp_reps_d != 2'h0) begin
                state_q <= ST_REPEAT;
              end
            end
          end
          ST_REPEAT: begin
            dac_word       <= hold_word_q;
            dac_word_valid <= 1'b1;
            rep_cnt_q      <= rep_cnt_q - 2'h1;
            if (rep_cnt_q == 2'h1) begin
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive bus
  // ---------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_bus_word  <= 10'h000;
      rx_bus_valid <= 1'b0;
    end else if (clk_en) begin
      if (loop_on) begin
        rx_bus_word  <= dac_word;
        rx_bus_valid <= dac_word_valid;
      end else begin
        rx_bus_word  <= adc_word;
        rx_bus_valid <= adc_word_valid & (fd_d | ~dir_eff);
      end
    end
  end
endmodule // imc_top

// [include/imc_defs.vh]
// Register map, field positions, reset values and encodings of the interface/clock block
`ifndef IMC_DEFS_VH
`define IMC_DEFS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define IMC_OFS_CLK_MODE      8'h01
`define IMC_OFS_DATA_PATH     8'h0d
`define IMC_OFS_IFACE_CFG     8'h0e
`define IMC_OFS_CLK_CFG_PRI   8'h0f
`define IMC_OFS_CLK_CFG_SEC   8'h10
`define IMC_OFS_STATUS        8'h1f

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define IMC_RST_CLK_MODE      8'h00
`define IMC_RST_DATA_PATH     8'h00
`define IMC_RST_IFACE_CFG     8'h10
`define IMC_RST_CLK_CFG_PRI   8'h00
`define IMC_RST_CLK_CFG_SEC   8'h00

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define IMC_BIT_LOOPBACK      5
`define IMC_BIT_DUPLEX        4
`define IMC_BIT_DIRECTION     3
`define IMC_BIT_WIDTH_10      2
`define IMC_BIT_DIR_OVERRIDE  1
`define IMC_BIT_CLONE         0
`define IMC_BIT_PLL_BYPASS    7
`define IMC_BIT_ADC_DIV2      5
`define IMC_BIT_ALT_TIMING    4
`define IMC_BIT_DIV5          3
`define IMC_MSB_MULT          2
`define IMC_BIT_LOOP_TO_PIN2  5
`define IMC_BIT_PIN2_ENABLE   2
`define IMC_MSB_CLK_MODE      7
`define IMC_LSB_CLK_MODE      5
`define IMC_MSB_INTERP        1

// ---------------------------------------------------------------
// Encodings and ratios
// ---------------------------------------------------------------
`define IMC_MULT_1X           3'h0
`define IMC_MULT_2X           3'h1
`define IMC_MULT_4X           3'h2
`define IMC_MULT_8X           3'h3
`define IMC_MULT_16X          3'h4
`define IMC_INTERP_NONE       2'h0
`define IMC_INTERP_2X         2'h1
`define IMC_INTERP_4X         2'h2
`define IMC_RATIO_DIV5        3'h5
`define IMC_RATIO_DIV2        3'h2
`define IMC_RATIO_NONE        3'h1

`endif
